/* File: sim/pfar_line_model.sv */
// far-end model: line clock and alternating slot zero words.
// assumes the receiver takes line_data on line_clk rising edges.
`timescale 1ns/1ps
module pfar_line_model
    import pfar_pkg::*;
(
    // word contents
    input  wire logic       bad_sync,
    input  wire logic       sync_b1,
    input  wire logic       ns_b1,
    input  wire logic [5:0] spare,
    // line
    output logic            line_clk,
    output logic            line_data,
    output logic            sync_now
);
    int         idx;
    logic [7:0] word;
    initial
    begin
        line_clk = 1'b0;
        line_data = 1'b0;
        sync_now = 1'b1;
        idx = 0;
        forever #244 line_clk = ~line_clk;
    end
    // data moves on the fall so it is settled at the rise
    always @(negedge line_clk)
    begin
        if (idx == 0)
            word = sync_now ? {sync_b1, bad_sync ? 7'h1A : SYNC_WORD}
                            : {ns_b1, 1'b1, spare};
        line_data <= (idx < 8) ? word[7 - idx] : 1'b0;
        idx = idx + 1;
        if (idx == 256)
        begin
            idx = 0;
            sync_now = ~sync_now;
        end
    end
endmodule : pfar_line_model

/* File: sim/pfar_receiver_tb.sv */
// self-checking bench for the frame alignment receiver.
// assumes the far-end model drives the line; registers over axi4-lite.
`timescale 1ns/1ps
module pfar_receiver_tb;
    import pfar_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        line_clk, line_data, sync_now, bad, sb1, nb1;
    logic        marker, fb1, nsb1, serr, alarm, trst_n;
    logic [5:0]  spare, spare_q;
    int          err_total = 0, n_checks = 0, cyc = 0;
    int          mk_w = 0, mk_last = 0, rs_w = 0, rs_last = 0, rs_cnt = 0;
    pfar_receiver u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .line_clk(line_clk), .line_data(line_data),
        .slot_zero_marker(marker), .frame_first_bit_out(fb1),
        .nonsync_first_bit_out(nsb1), .spare_bits_out(spare_q),
        .sync_error(serr), .align_alarm(alarm), .terminal_reset_n(trst_n)
    );
    pfar_line_model u_far (
        .bad_sync(bad), .sync_b1(sb1), .ns_b1(nb1), .spare(spare),
        .line_clk(line_clk), .line_data(line_data), .sync_now(sync_now)
    );
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // pulse widths and reset pulse count, plus the hang limit
    always @(posedge aclk)
    begin
        mk_w <= marker ? mk_w + 1 : 0;
        if (!marker && mk_w > 0) mk_last <= mk_w;
        rs_w <= !trst_n ? rs_w + 1 : 0;
        if (trst_n && rs_w > 0)
        begin
            rs_last <= rs_w;
            rs_cnt <= rs_cnt + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 98000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    // fall = 1 waits for the marker to end, else for it to start
    task automatic next_mark(input logic fall);
        repeat (6000)
        begin
            @(posedge aclk);
            if (fall ? (marker === 1'b0 && mk_w > 0)
                     : (marker === 1'b1 && mk_w == 0)) return;
        end
        chk(32'h0, 32'h1);
    endtask : next_mark
    task automatic wait_alarm(input logic v);
        repeat (35000)
        begin
            @(posedge aclk);
            if (alarm === v) return;
        end
        chk(32'h0, 32'h1);
    endtask : wait_alarm
    initial
    begin : main
        logic [31:0] d;
        logic [1:0]  r;
        int          k;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {bad, sb1, nb1} = 3'h1;
        spare = 6'h2D;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFS, d, r);
        chk(d, 32'h1);
        axi_rd(STATUS_OFS, d, r);
        chk(d & 32'h7B, 32'h1A);
        axi_wr(8'h10, 32'h1, r);
        chk(32'(r), 32'(RESP_SLVERR));
        axi_rd(8'h10, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wait_alarm(1'b0);
        axi_rd(STATUS_OFS, d, r);
        chk(d & 32'h3, 32'h1);
        sb1 <= 1'b1;
        nb1 <= 1'b0;
        spare <= 6'h12;
        next_mark(1'b1);
        repeat (50) @(posedge aclk);
        k = rs_cnt;
        repeat (10000) @(posedge aclk);
        chk(32'(rs_cnt - k), 32'h1);
        chk(32'(rs_last >= 19 && rs_last <= 21), 32'h1);
        chk(32'(mk_last >= 155 && mk_last <= 158), 32'h1);
        chk({29'h0, fb1, nsb1, 1'b0}, 32'h4);
        chk(32'(spare_q), 32'h12);
        next_mark(1'b0);
        if (sync_now) next_mark(1'b0);
        bad <= 1'b1;
        repeat (5) next_mark(1'b0);
        chk({30'h0, alarm, serr}, 32'h0);
        next_mark(1'b1);
        repeat (3) @(posedge aclk);
        chk({30'h0, alarm, serr}, 32'h3);
        bad <= 1'b0;
        axi_rd(ERRCNT_OFS, d, r);
        chk(d, 32'h3);
        wait_alarm(1'b0);
        axi_rd(STATUS_OFS, d, r);
        chk(d & 32'h60, 32'h60);
        k = 0;
        repeat (9)
        begin
            axi_rd(DATA_OFS, d, r);
            k += d[31];
        end
        chk(32'(k), 32'h8);
        chk(32'(d[31]), 32'h0);
        axi_wr(STATUS_OFS, 32'h20, r);
        axi_rd(STATUS_OFS, d, r);
        chk(d & 32'h30, 32'h10);
        axi_wr(CTRL_OFS, 32'h3, r);
        axi_rd(STATUS_OFS, d, r);
        chk(d & 32'hF, 32'hE);
        axi_wr(CTRL_OFS, 32'h0, r);
        axi_rd(CTRL_OFS, d, r);
        chk(d, 32'h0);
        final_report();
    end
endmodule : pfar_receiver_tb

/* File: verilog/pfar_fifo.sv */
// small synchronous fifo holding captured slot zero words.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module pfar_fifo
    import pfar_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } pfar_fifo_state_t;

    pfar_fifo_state_t state_reg;
    pfar_fifo_state_t state_next;
    logic             push;
    logic             pop;

    assign in_ready  = (state_reg.count != CNT_FULL);
    assign out_valid = (state_reg.count != '0);
    assign out_data  = state_reg.mem[state_reg.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.mem[state_reg.wr_ptr] = in_data;
            state_next.wr_ptr = (state_reg.wr_ptr == PTR_LAST) ? '0
                                : state_reg.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            state_next.rd_ptr = (state_reg.rd_ptr == PTR_LAST) ? '0
                                : state_reg.rd_ptr + 1'b1;
        end
        if (push && !pop)
            state_next.count = state_reg.count + 1'b1;
        else if (pop && !push)
            state_next.count = state_reg.count - 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

endmodule : pfar_fifo

/* File: verilog/pfar_pkg.sv */
// package of constants for the pcm frame alignment receiver.
// assumes a 40 MHz aclk and a 2.048 MHz line bit clock on a pin.
//
// Overview of operation
// (R1) shift line bits through shifter, detect sync
// (R2) outside supplies 2.048 MHz line bit clock
// (R3) three bad sync words declare alignment loss
// (R4) aligned: reset low one bit after slot zero; the code pulses it after sync-frame slot zero only
// (R5) slot zero marker high eight bit periods
// (R6) non-sync bit one output updated at slot one
// (R7) sync bit one output updated at slot one
// (R8) six spare bits from non-sync slot zero
// (R9) error rises third sync frame after errored
// (R10) error stays high while errors keep coming
// (R11) error held high while alarm raised
// (R12) alarm rises at marker end, third bad
// (R13) alarm falls after three correct frames
// (R14) sync pattern 0011011, non-sync bit two one
// (R15) frame is 256 bits, frames alternate
// (R16) hunt for sync word and rephase counters
package pfar_pkg;

    localparam int          CLK_PERIOD_PS  = 25000;
    localparam int          LINE_CLK_KHZ   = 2048;
    localparam int          LINE_PERIOD_PS = 1000000000 / (LINE_CLK_KHZ * 1000)
                                             * 1000;
    localparam int          CLK_PER_BIT    = LINE_PERIOD_PS / CLK_PERIOD_PS;

    localparam logic [6:0]  SYNC_WORD      = 7'h1B;
    localparam int          SLOT_BITS      = 8;
    localparam logic [7:0]  SLOT_END       = 8'h07;
    localparam logic [7:0]  SLOT_AFTER     = 8'h08;
    localparam logic [7:0]  FRAME_LAST     = 8'hFF;
    localparam logic [1:0]  LOSS_COUNT     = 2'h3;
    localparam logic [1:0]  REGAIN_COUNT   = 2'h3;
    localparam int          ERR_DELAY      = 3;

    localparam logic [7:0]  CTRL_OFS       = 8'h00;
    localparam logic [7:0]  STATUS_OFS     = 8'h04;
    localparam logic [7:0]  DATA_OFS       = 8'h08;
    localparam logic [7:0]  ERRCNT_OFS     = 8'h0C;

    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_HUNT_BIT  = 1;
    localparam int          STAT_OVF_BIT   = 5;
    localparam logic        CTRL_EN_RST    = 1'b1;

    localparam int          FIFO_WIDTH     = 10;
    localparam int          FIFO_DEPTH     = 8;

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : pfar_pkg

/* File: verilog/pfar_receiver.sv */
// pcm frame alignment receiver with an axi4-lite register slave.
// assumes line_clk and line_data come from pins, asynchronous to aclk,
// and that line_clk runs much slower than aclk (at least 4x).
`timescale 1ns/1ps
module pfar_receiver
    import pfar_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pcm line
    input  wire logic        line_clk,
    input  wire logic        line_data,
    // frame outputs
    output logic             slot_zero_marker,
    output logic             frame_first_bit_out,
    output logic             nonsync_first_bit_out,
    output logic [5:0]       spare_bits_out,
    output logic             sync_error,
    output logic             align_alarm,
    output logic             terminal_reset_n
);

    typedef struct packed {
        logic [1:0]           din_s;
        logic [1:0]           lclk_s;
        logic                 lclk_d;
        logic [7:0]           shift;
        logic [7:0]           cnt;
        logic                 sf;
        logic                 hunting;
        logic                 pend;
        logic                 pend_ok;
        logic                 pend_sync;
        logic [7:0]           byte0;
        logic [1:0]           bad_cnt;
        logic [1:0]           good_cnt;
        logic [ERR_DELAY:0]   err_pipe;
        logic                 marker;
        logic                 first_sf;
        logic                 first_nsf;
        logic [5:0]           spare;
        logic                 error;
        logic                 alarm;
        logic                 trst_n;
        logic                 enable;
        logic                 ovf;
        logic [15:0]          err_total;
        logic                 aw_full;
        logic [7:0]           aw_addr;
        logic                 w_full;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 awready;
        logic                 wready;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 arready;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } pfar_state_t;

    localparam pfar_state_t STATE_RST = '{
        cnt: FRAME_LAST, hunting: 1'b1, alarm: 1'b1, trst_n: 1'b1, error: 1'b1,
        enable: CTRL_EN_RST, awready: 1'b1, wready: 1'b1,
        arready: 1'b1, default: '0};

    pfar_state_t                 state_reg;
    pfar_state_t                 state_next;
    logic                        bit_en;
    logic                        fifo_in_ready;
    logic                        fifo_push;
    logic                        fifo_out_valid;
    logic                        fifo_pop;
    logic [FIFO_WIDTH-1:0]       fifo_out_data;
    logic [FIFO_WIDTH-1:0]       fifo_in_data;

    // line clock rising edge, seen only after both sync stages
    assign bit_en    = state_reg.lclk_s[1] && !state_reg.lclk_d
                       && state_reg.enable;
    assign fifo_push = bit_en && state_reg.pend;
    assign fifo_in_data = {state_reg.pend_sync, state_reg.pend_ok,
                           state_reg.byte0};
    assign fifo_pop  = s_axi_arvalid && state_reg.arready
                       && (s_axi_araddr == DATA_OFS);

    pfar_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always_comb
    begin
        logic [7:0] sh;
        logic [7:0] cnt_n;
        logic       sf_n;
        logic       force_hunt;
        sh         = '0;
        cnt_n      = '0;
        sf_n       = 1'b0;
        force_hunt = 1'b0;
        state_next = state_reg;
        state_next.din_s  = {state_reg.din_s[0], line_data};
        state_next.lclk_s = {state_reg.lclk_s[0], line_clk};
        state_next.lclk_d = state_reg.lclk_s[1];

        // register writes: address and data may arrive in either order
        if (s_axi_awvalid && state_reg.awready)
        begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready)
        begin
            state_next.w_full = 1'b1;
            state_next.wdata  = s_axi_wdata;
            state_next.wstrb  = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready)
            state_next.bvalid = 1'b0;
        if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid)
        begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            unique case (state_reg.aw_addr)
                CTRL_OFS:
                    if (state_reg.wstrb[0])
                    begin
                        state_next.enable = state_reg.wdata[CTRL_EN_BIT];
                        force_hunt = state_reg.wdata[CTRL_HUNT_BIT];
                    end
                STATUS_OFS:
                    if (state_reg.wstrb[0] && state_reg.wdata[STAT_OVF_BIT])
                        state_next.ovf = 1'b0;
                DATA_OFS, ERRCNT_OFS: ;
                default:
                    state_next.bresp = RESP_SLVERR;
            endcase
        end
        state_next.awready = !state_next.aw_full;
        state_next.wready  = !state_next.w_full;

        // register reads; a read of the data word pops the fifo
        if (state_reg.rvalid && s_axi_rready)
        begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end
        if (s_axi_arvalid && state_reg.arready)
        begin
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rresp   = RESP_OKAY;
            state_next.rdata   = '0;
            unique case (s_axi_araddr)
                CTRL_OFS:
                    state_next.rdata[CTRL_EN_BIT] = state_reg.enable;
                STATUS_OFS:
                    state_next.rdata[6:0] = {!fifo_in_ready, state_reg.ovf,
                        !fifo_out_valid, state_reg.hunting, state_reg.error,
                        state_reg.alarm, !state_reg.alarm};
                DATA_OFS:
                    state_next.rdata = {fifo_out_valid, 21'h000000,
                                        fifo_out_data};
                ERRCNT_OFS:
                    state_next.rdata[15:0] = state_reg.err_total;
                default:
                    state_next.rresp = RESP_SLVERR;
            endcase
        end

        if (bit_en)
        begin
            sh = {state_reg.shift[6:0], state_reg.din_s[1]};        // R1
            state_next.shift = sh;
            cnt_n = state_reg.cnt + 8'h01;                          // R15
            sf_n  = (state_reg.cnt == FRAME_LAST) ? !state_reg.sf
                    : state_reg.sf;
            state_next.pend = 1'b0;
            if (state_reg.hunting)
            begin
                // any bit position may end a sync word while hunting
                if (sh[6:0] == SYNC_WORD)                           // R16
                begin
                    cnt_n = SLOT_END;
                    sf_n  = 1'b1;
                    state_next.hunting   = 1'b0;
                    state_next.pend      = 1'b1;
                    state_next.pend_ok   = 1'b1;
                    state_next.pend_sync = 1'b1;
                    state_next.byte0     = sh;
                end
            end
            else if (cnt_n == SLOT_END)
            begin
                state_next.pend      = 1'b1;
                state_next.pend_sync = state_reg.sf;
                state_next.pend_ok   = state_reg.sf                 // R14
                                       ? (sh[6:0] == SYNC_WORD) : sh[6];
                state_next.byte0     = sh;
            end
            state_next.cnt    = cnt_n;
            state_next.sf     = sf_n;
            state_next.marker = (cnt_n < 8'(SLOT_BITS));            // R5
            state_next.trst_n = 1'b1;

            // first bit of slot one: judge slot zero, publish its bits
            if (state_reg.pend)
            begin
                if (state_reg.pend_sync)
                begin
                    state_next.first_sf = state_reg.byte0[7];       // R7
                    state_next.err_pipe = {state_reg.err_pipe[ERR_DELAY-1:0],
                                           !state_reg.pend_ok};     // R9
                end
                else
                begin
                    state_next.first_nsf = state_reg.byte0[7];      // R6
                    state_next.spare     = state_reg.byte0[5:0];    // R8
                end
                if (!state_reg.alarm)
                begin
                    if (state_reg.pend_sync && !state_reg.pend_ok)
                    begin
                        if (state_reg.err_total != 16'hFFFF)
                            state_next.err_total = state_reg.err_total
                                                   + 16'h0001;
                        if (state_reg.bad_cnt == LOSS_COUNT - 2'h1) // R3
                        begin
                            state_next.alarm   = 1'b1;              // R12
                            state_next.hunting = 1'b1;
                            state_next.bad_cnt = '0;
                        end
                        else
                            state_next.bad_cnt = state_reg.bad_cnt + 2'h1;
                    end
                    else if (state_reg.pend_sync)
                        state_next.bad_cnt = '0;
                end
                else if (state_reg.pend_ok)
                begin
                    if (state_reg.good_cnt == REGAIN_COUNT - 2'h1)  // R13
                    begin
                        state_next.alarm    = 1'b0;
                        state_next.good_cnt = '0;
                        state_next.err_pipe = '0;
                    end
                    else
                        state_next.good_cnt = state_reg.good_cnt + 2'h1;
                end
                else
                begin
                    // a failed check while regaining starts the hunt over
                    state_next.hunting  = 1'b1;
                    state_next.good_cnt = '0;
                end
                state_next.trst_n = !(state_reg.pend_sync               // R4
                                      && !state_next.alarm);
                if (!fifo_in_ready)
                    state_next.ovf = 1'b1;
            end
            // error follows the delayed per-frame flag, alarm forces it
            state_next.error = state_next.err_pipe[ERR_DELAY]      // R10
                               || state_next.alarm;                 // R11
        end

        if (force_hunt)
        begin
            state_next.hunting  = 1'b1;
            state_next.alarm    = 1'b1;
            state_next.error    = 1'b1;
            state_next.good_cnt = '0;
            state_next.bad_cnt  = '0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= STATE_RST;
        else
            state_reg <= state_next;
    end

    assign s_axi_awready         = state_reg.awready;
    assign s_axi_wready          = state_reg.wready;
    assign s_axi_bvalid          = state_reg.bvalid;
    assign s_axi_bresp           = state_reg.bresp;
    assign s_axi_arready         = state_reg.arready;
    assign s_axi_rvalid          = state_reg.rvalid;
    assign s_axi_rdata           = state_reg.rdata;
    assign s_axi_rresp           = state_reg.rresp;
    assign slot_zero_marker      = state_reg.marker;
    assign frame_first_bit_out   = state_reg.first_sf;
    assign nonsync_first_bit_out = state_reg.first_nsf;
    assign spare_bits_out        = state_reg.spare;
    assign sync_error            = state_reg.error;
    assign align_alarm           = state_reg.alarm;
    assign terminal_reset_n      = state_reg.trst_n;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_slot_judged;
        bit_en && state_reg.pend;
    endsequence

    chk_shift_in_bit: assert property (bit_en |=> // R1
        state_reg.shift[0] == $past(state_reg.din_s[1]))
        else $error("shifter did not take the line bit");
    chk_loss_third_bad: assert property ($rose(align_alarm) // R3
        && $past(bit_en && state_reg.pend && !state_reg.hunting)
        |-> $past(state_reg.bad_cnt) == 2'h2)
        else $error("alarm raised before third bad sync word");
    chk_reset_pulse: assert property (!terminal_reset_n |-> // R4
        !align_alarm && state_reg.cnt == SLOT_AFTER)
        else $error("terminal reset low outside aligned slot one");
    chk_marker_span: assert property (slot_zero_marker |-> // R5
        state_reg.cnt < 8'(SLOT_BITS))
        else $error("slot zero marker outside first eight bits");
    chk_spare_update: assert property ($changed(spare_bits_out) |-> // R8
        $past(state_reg.pend) && !$past(state_reg.pend_sync))
        else $error("spare bits changed outside non-sync slot one");
    chk_sync_bit_upd: assert property ($changed(frame_first_bit_out) // R7
        |-> $past(state_reg.pend_sync) && state_reg.cnt == SLOT_AFTER)
        else $error("sync first bit changed outside sync slot one");
    chk_error_held: assert property (align_alarm && !$rose(align_alarm) // R11
        |-> sync_error)
        else $error("error low while alarm stands");
    chk_alarm_fall: assert property (s_slot_judged // R13
        ##1 $fell(align_alarm) |-> $past(state_reg.good_cnt, 2) == 2'h2)
        else $error("alarm cleared before third good frame");
    chk_hunt_phase: assert property (bit_en && state_reg.hunting // R16
        && ({state_reg.shift[5:0], state_reg.din_s[1]} == SYNC_WORD)
        |=> state_reg.cnt == SLOT_END && state_reg.sf && state_reg.pend)
        else $error("hunt did not rephase on sync word");

endmodule : pfar_receiver
